//--- src/tbwd_defines.svh
/*
 Timing constants and field positions for the time-base and watchdog block.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef TBWD_DEFINES_SVH
`define TBWD_DEFINES_SVH

// Time-base counter width and interval tap positions (oscillation clock bits, one above the main-clock count bit)
`define TB_WIDTH          18
`define TB_TAP_SEL0       11
`define TB_TAP_SEL1       13
`define TB_TAP_SEL2       15
`define TB_TAP_SEL3       18
// Watchdog source taps on the time-base counter
`define WD_TB_TAP_SEL0    11
`define WD_TB_TAP_SEL1    13
`define WD_TB_TAP_SEL2    15
`define WD_TB_TAP_SEL3    18
// Watchdog source taps on the watch counter (subclock bits)
`define WT_WIDTH          15
`define WD_WT_TAP_SEL0    9
`define WD_WT_TAP_SEL1    12
`define WD_WT_TAP_SEL2    13
`define WD_WT_TAP_SEL3    14
// Watchdog counter and reset pulse
`define WD_WIDTH          2
`define WD_RESET_PULSE    4
// Interrupt request number of the time-base
`define TB_IRQ_NUMBER     8'h10

`endif

//--- src/tbwd_pkg.sv
/*
 Types shared by the time-base and watchdog block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tbwd_pkg;
    typedef logic [1:0] sel2_t;
    typedef enum logic [1:0] {
        WD_IDLE,
        WD_RUN,
        WD_FIRE
    } wd_state_t;
endpackage : tbwd_pkg

//--- src/tap_edge.sv
/*
 Rising-edge detector on one selected bit of a counter: a single tick per
 transition from 0 to 1 of the chosen tap.
 Assumes the counter and select share clock_in.
*/
`timescale 1ns/1ps
module tap_edge
    import tbwd_pkg::*;
#(
    parameter int WIDTH = 18,
    parameter int TAP0  = 11,
    parameter int TAP1  = 13,
    parameter int TAP2  = 15,
    parameter int TAP3  = 17
) (
    input  wire logic             clock_in,   // System clock
    input  wire logic             sys_rst_in, // Async reset, high
    input  wire logic [WIDTH-1:0] count_in,   // Counter to tap
    input  wire sel2_t            sel_in,     // Tap select
    output logic                  tick_out    // One-cycle tick
);
    initial begin
        if (TAP0 >= WIDTH || TAP1 >= WIDTH || TAP2 >= WIDTH || TAP3 >= WIDTH) begin
            $error("tap_edge: tap outside counter");
        end
    end

    logic bit_now;
    logic bit_r;

    // Tap mux
    always_comb begin
        unique case (sel_in)
            2'd0: bit_now = count_in[TAP0];
            2'd1: bit_now = count_in[TAP1];
            2'd2: bit_now = count_in[TAP2];
            2'd3: bit_now = count_in[TAP3];
        endcase
    end

    // Last tap value; a falling tap after a counter clear makes no tick
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bit_r <= 1'b0;
        end else begin
            bit_r <= bit_now;
        end
    end

    assign tick_out = bit_now & ~bit_r;
endmodule : tap_edge

//--- src/timebase_watchdog_timer.sv
/*
 Time-base counter with interval flag and interrupt, plus a 2-bit watchdog
 fed by either the time-base or the watch counter.
 Assumes clock_in is the oscillation clock; subclock ticks arrive as a
 synchronous one-cycle strobe; all control bits are synchronous ports.
*/
// How it works
// - An 18-bit up counter advances once per main clock, every second oscillation cycle.
// - A two-bit select picks an interval of 2^12, 2^14, 2^16 or 2^19 oscillation periods.
// - Reaching the selected interval sets the overflow flag and requests an interrupt.
// - The interrupt output is high only while the enable and the flag are both one.
// - The counter bits are offered out for stabilization waits and peripheral clocks.
// - The interrupt is identified as request number 16, hex 10.
// - The watchdog is a 2-bit counter advanced by ticks of the selected source.
// - Once launched, an uncleared watchdog resets the CPU when its interval runs out.
// - A source select bit chooses time-base output or watch output for the watchdog.
// - A two-bit field picks which tap of that source clocks the watchdog.
// - Time-base intervals are 2^14, 2^16, 2^18 or 2^21 oscillation cycles within one eighth.
// - Watch intervals are 2^12, 2^15, 2^16 or 2^17 subclock cycles within one eighth.
// - Clearing the time-base delays the next watchdog tick from that source.
`timescale 1ns/1ps
`include "tbwd_defines.svh"
module timebase_watchdog_timer
    import tbwd_pkg::*;
#(
    parameter int TB_W = `TB_WIDTH,
    parameter int WT_W = `WT_WIDTH
) (
    input  wire logic            clock_in,           // Oscillation clock, 200 MHz
    input  wire logic            sys_rst_in,         // Async reset, high
    input  wire logic            tb_interval_sel_hi, // Time-base interval select bit 1
    input  wire logic            tb_interval_sel_lo, // Time-base interval select bit 0
    input  wire logic            tb_irq_enable,      // Interrupt enable
    input  wire logic            tb_flag_clear_in,   // Pulse: clear overflow flag
    input  wire logic            tb_counter_clear_in,// Pulse: clear time-base counter
    input  wire logic            wd_clock_source_sel,// 1 time-base, 0 watch output
    input  wire logic            wd_interval_sel_hi, // Watchdog interval bit 1
    input  wire logic            wd_interval_sel_lo, // Watchdog interval bit 0
    input  wire logic            wd_launch_in,       // Pulse: launch watchdog
    input  wire logic            wd_clear_in,        // Pulse: clear watchdog counter
    input  wire logic            subclk_tick_in,     // One-cycle subclock strobe
    output logic                 tb_overflow_flag,   // Sticky overflow flag
    output logic                 tb_irq_out,         // Interrupt request, level
    output logic [7:0]           tb_irq_num_out,     // Request number, constant
    output logic [TB_W-1:0]      tb_count_out,       // Counter taps for peripherals
    output logic [`WD_WIDTH-1:0] wd_count_out,       // Watchdog count
    output logic                 wd_running_out,     // Watchdog launched
    output logic                 cpu_reset_out       // CPU reset pulse, high
);
    initial begin
        if (TB_W != `TB_WIDTH || WT_W != `WT_WIDTH) begin
            $error("timebase_watchdog_timer: taps fixed for 18/15-bit counters");
        end
    end

    logic              half_r;       // Main-clock phase
    logic [TB_W-1:0]   tb_cnt_r;
    logic [WT_W-1:0]   wt_cnt_r;
    logic              tb_tick;
    logic              wdtb_tick;
    logic              wdwt_tick;
    logic              wd_tick;
    logic [`WD_WIDTH-1:0] wd_cnt_r;
    wd_state_t         wd_state_r;
    logic [2:0]        rst_cnt_r;
    sel2_t             tb_sel;
    sel2_t             wd_sel;
    logic              wd_tap_now;   // Selected watchdog tap level
    logic              wd_tap_r;     // Tap level one cycle back
    logic              tb_clr_d_r;   // Time-base clear, one cycle late
    logic              wd_fall;      // Selected tap fell
    logic              wd_tail_r;    // Fourth tick seen, waiting for the fall

    assign tb_sel = {tb_interval_sel_hi, tb_interval_sel_lo};
    assign wd_sel = {wd_interval_sel_hi, wd_interval_sel_lo};

    // Main clock is every other oscillation edge
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            half_r <= 1'b0;
        end else begin
            half_r <= ~half_r;
        end
    end

    // Time-base counter; software clear restarts it
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tb_cnt_r <= '0;
        end else if (tb_counter_clear_in) begin
            tb_cnt_r <= '0;
        end else if (half_r) begin
            tb_cnt_r <= tb_cnt_r + 1'b1;
        end
    end

    // Watch counter, subclock-driven source only
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wt_cnt_r <= '0;
        end else if (subclk_tick_in) begin
            wt_cnt_r <= wt_cnt_r + 1'b1;
        end
    end

    assign tb_count_out = tb_cnt_r;

    // Bit k of the main-clock count rises every 2^(k+2) oscillation cycles
    tap_edge #(.WIDTH(TB_W), .TAP0(`TB_TAP_SEL0 - 1), .TAP1(`TB_TAP_SEL1 - 1),
               .TAP2(`TB_TAP_SEL2 - 1), .TAP3(`TB_TAP_SEL3 - 1)) u_tb_int (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .count_in   (tb_cnt_r),
        .sel_in     (tb_sel),
        .tick_out   (tb_tick)
    );

    // Watchdog taps one source period a quarter of its interval
    tap_edge #(.WIDTH(TB_W), .TAP0(`WD_TB_TAP_SEL0 - 1), .TAP1(`WD_TB_TAP_SEL1 - 1),
               .TAP2(`WD_TB_TAP_SEL2 - 1), .TAP3(`WD_TB_TAP_SEL3 - 1)) u_wd_tb (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .count_in   (tb_cnt_r),
        .sel_in     (wd_sel),
        .tick_out   (wdtb_tick)
    );

    tap_edge #(.WIDTH(WT_W), .TAP0(`WD_WT_TAP_SEL0), .TAP1(`WD_WT_TAP_SEL1),
               .TAP2(`WD_WT_TAP_SEL2), .TAP3(`WD_WT_TAP_SEL3)) u_wd_wt (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .count_in   (wt_cnt_r),
        .sel_in     (wd_sel),
        .tick_out   (wdwt_tick)
    );

    assign wd_tick = wd_clock_source_sel ? wdtb_tick : wdwt_tick;

    // Level of the watchdog's selected tap; its fall times the last half period
    always_comb begin
        if (wd_clock_source_sel) begin
            unique case (wd_sel)
                2'h0: wd_tap_now = tb_cnt_r[`WD_TB_TAP_SEL0 - 1];
                2'h1: wd_tap_now = tb_cnt_r[`WD_TB_TAP_SEL1 - 1];
                2'h2: wd_tap_now = tb_cnt_r[`WD_TB_TAP_SEL2 - 1];
                2'h3: wd_tap_now = tb_cnt_r[`WD_TB_TAP_SEL3 - 1];
            endcase
        end else begin
            unique case (wd_sel)
                2'h0: wd_tap_now = wt_cnt_r[`WD_WT_TAP_SEL0];
                2'h1: wd_tap_now = wt_cnt_r[`WD_WT_TAP_SEL1];
                2'h2: wd_tap_now = wt_cnt_r[`WD_WT_TAP_SEL2];
                2'h3: wd_tap_now = wt_cnt_r[`WD_WT_TAP_SEL3];
            endcase
        end
    end

    // Tap history and a delayed time-base clear; both start at the idle level 0
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wd_tap_r   <= 1'b0;
            tb_clr_d_r <= 1'b0;
        end else begin
            wd_tap_r   <= wd_tap_now;
            tb_clr_d_r <= tb_counter_clear_in;
        end
    end

    // A fall forced by a time-base clear is ignored, so a clear only lengthens
    // the time to reset; a source switch during the tail may still end it early
    assign wd_fall = wd_tap_r & ~wd_tap_now & ~(tb_clr_d_r & wd_clock_source_sel);

    // Overflow flag; a new overflow wins over a clear in the same cycle
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tb_overflow_flag <= 1'b0;
        end else if (tb_tick) begin
            tb_overflow_flag <= 1'b1;
        end else if (tb_flag_clear_in) begin
            tb_overflow_flag <= 1'b0;
        end
    end

    assign tb_irq_out     = tb_irq_enable & tb_overflow_flag;
    assign tb_irq_num_out = `TB_IRQ_NUMBER;

    // Watchdog: four ticks uncleared, then the next fall of the tap, fire the
    // reset; the first tick lands anywhere in a tap period, so a clear is
    // followed by 3.5 to 4.5 tap periods, the plus-or-minus eighth spread
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wd_state_r <= WD_IDLE;
            wd_cnt_r   <= '0;
            wd_tail_r  <= 1'b0;
            rst_cnt_r  <= '0;
        end else begin
            unique case (wd_state_r)
                WD_IDLE: begin
                    if (wd_launch_in) begin
                        wd_state_r <= WD_RUN;
                        wd_cnt_r   <= '0;
                        wd_tail_r  <= 1'b0;
                    end
                end
                WD_RUN: begin
                    if (wd_clear_in || wd_launch_in) begin
                        wd_cnt_r  <= '0;
                        wd_tail_r <= 1'b0;
                    end else if (wd_tail_r) begin
                        if (wd_fall) begin
                            wd_state_r <= WD_FIRE;
                            wd_tail_r  <= 1'b0;
                            rst_cnt_r  <= 3'(`WD_RESET_PULSE);
                        end
                    end else if (wd_tick) begin
                        if (wd_cnt_r == 2'h3) begin
                            wd_tail_r <= 1'b1;
                        end
                        wd_cnt_r <= wd_cnt_r + 1'b1;
                    end
                end
                WD_FIRE: begin
                    // The CPU reset also stops the watchdog until relaunch
                    if (rst_cnt_r == 3'd1) begin
                        wd_state_r <= WD_IDLE;
                    end
                    rst_cnt_r <= rst_cnt_r - 1'b1;
                end
                default: begin
                    wd_state_r <= WD_IDLE;
                end
            endcase
        end
    end

    assign wd_count_out   = wd_cnt_r;
    assign wd_running_out = (wd_state_r == WD_RUN);
    assign cpu_reset_out  = (wd_state_r == WD_FIRE);
endmodule : timebase_watchdog_timer

//--- verif/tbwd_monitor.sv
/*
 Port checker for the time-base and watchdog block.
 Assumes it is bound onto every instance of that block.
*/
`timescale 1ns/1ps
module tbwd_monitor #(
    parameter int TB_W = 18
) (
    input wire logic            clock_in,            // Clock
    input wire logic            sys_rst_in,          // Reset
    input wire logic            tb_interval_sel_hi,  // Select
    input wire logic            tb_interval_sel_lo,  // Select
    input wire logic            tb_irq_enable,       // Enable
    input wire logic            tb_flag_clear_in,    // Flag clear
    input wire logic            tb_counter_clear_in, // Count clear
    input wire logic            tb_overflow_flag,    // Flag
    input wire logic            tb_irq_out,          // Interrupt
    input wire logic [7:0]      tb_irq_num_out,      // Number
    input wire logic [TB_W-1:0] tb_count_out,        // Count
    input wire logic [1:0]      wd_count_out,        // Dog count
    input wire logic            wd_running_out,      // Running
    input wire logic            cpu_reset_out        // CPU reset
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // Interval taps in main-clock bits, picked by the select
    wire logic [3:0] taps = {tb_count_out[17], tb_count_out[14],
                             tb_count_out[12], tb_count_out[10]};
    wire logic tap_bit = taps[{tb_interval_sel_hi, tb_interval_sel_lo}];
    // Clears are excluded since they do not restart the half phase
    property p_tb_inc;
        $changed(tb_count_out) && !tb_counter_clear_in && !$past(tb_counter_clear_in)
            |=> tb_count_out == $past(tb_count_out);
    endproperty
    a_tb_inc: assert property (p_tb_inc) else $error("count step");
    property p_tb_step;
        $changed(tb_count_out) && !$past(tb_counter_clear_in)
            |-> tb_count_out == $past(tb_count_out) + 1'b1;
    endproperty
    a_tb_step: assert property (p_tb_step) else $error("count value");
    property p_flag;
        $rose(tap_bit) && $stable({tb_interval_sel_hi, tb_interval_sel_lo}) |=> tb_overflow_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_clr;
        tb_flag_clear_in && !$rose(tap_bit) |=> !tb_overflow_flag;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_irq;
        tb_irq_out == (tb_irq_enable && tb_overflow_flag);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level");
    property p_num;
        tb_irq_num_out == 8'h10;
    endproperty
    a_num: assert property (p_num) else $error("irq number");
    property p_wd_step;
        $changed(wd_count_out)
            |-> wd_count_out == 2'h0 || wd_count_out == $past(wd_count_out) + 1'b1;
    endproperty
    a_wd_step: assert property (p_wd_step) else $error("dog step");
    property p_pulse;
        $rose(cpu_reset_out) |-> cpu_reset_out[*4] ##1 !cpu_reset_out && !wd_running_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse");
    property p_rst;
        disable iff (1'b0) sys_rst_in
            |-> tb_count_out == '0 && !tb_overflow_flag && wd_count_out == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    c_irq: cover property ($rose(tb_irq_out));
    c_dog: cover property ($rose(cpu_reset_out));
    c_hold: cover property (tb_counter_clear_in && tb_count_out != '0);
endmodule : tbwd_monitor

bind timebase_watchdog_timer tbwd_monitor #(.TB_W(TB_W)) u_mon (.*);

//--- verif/cpu_model.sv
/*
 CPU and software model: takes interrupts, services the watchdog.
 Assumes the timer block on the same clock.
*/
`timescale 1ns/1ps
module cpu_model #(
    parameter int PERIOD = 2000
) (
    input  wire logic clock_in,       // Clock
    input  wire logic sys_rst_in,     // Reset
    input  wire logic tb_irq_out,     // Interrupt
    input  wire logic cpu_reset_out,  // Dog reset
    input  wire logic ack_en_in,      // Handle irq
    input  wire logic svc_en_in,      // Service dog
    output logic      flag_clear_out, // Flag clear
    output logic      wd_clear_out,   // Dog clear
    output int        resets_out      // Reset cycles
);
    int gap_r; // Cycles since service
    // One ack per request; service gap kept inside the shortest interval
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {flag_clear_out, wd_clear_out, gap_r, resets_out} <= '0;
        end else begin
            flag_clear_out <= #1 ack_en_in && tb_irq_out && !flag_clear_out;
            wd_clear_out   <= #1 svc_en_in && gap_r == PERIOD;
            gap_r          <= (gap_r == PERIOD) ? 0 : gap_r + 1;
            resets_out     <= resets_out + int'(cpu_reset_out);
        end
    end
endmodule : cpu_model

//--- verif/testbench.sv
/*
 Self-checking bench for the time-base and watchdog block.
 Assumes the CPU model and the bound port checker.
*/
`timescale 1ns/1ps
module testbench;
    logic clock_in, sys_rst_in, tb_interval_sel_hi, tb_interval_sel_lo, tb_irq_enable;
    logic tb_flag_clear_in, tb_counter_clear_in, wd_clock_source_sel, wd_interval_sel_hi;
    logic wd_interval_sel_lo, wd_launch_in, wd_clear_in, subclk_tick_in, ack_en, svc_en;
    logic        tb_overflow_flag, tb_irq_out, wd_running_out, cpu_reset_out;
    logic [7:0]  tb_irq_num_out;
    logic [17:0] tb_count_out;
    logic [1:0]  wd_count_out;
    int          resets, mismatches, samples_checked, cycles, c0;

    timebase_watchdog_timer u_dut (.*);
    cpu_model #(.PERIOD(2000)) u_cpu (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .tb_irq_out(tb_irq_out), .cpu_reset_out(cpu_reset_out), .ack_en_in(ack_en),
        .svc_en_in(svc_en), .flag_clear_out(tb_flag_clear_in), .wd_clear_out(wd_clear_in),
        .resets_out(resets));

    // Clock at 200 MHz
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    // Hang guard, above the planned run of about 83k cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 95000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask : tick
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %b got %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_span(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
        end
    endtask : check_span
    // Bounded wait for the flag or the watchdog reset
    task automatic wait_for(input logic on_rst);
        int k = 0;
        while ((on_rst ? cpu_reset_out : tb_overflow_flag) !== 1'b1 && k < 20000) begin
            tick(1);
            k++;
        end
        // A wait that runs out is a mismatch of its own
        if (k == 20000) begin
            mismatches++;
            $display("BAD wait_for exp 1 got %b", on_rst ? cpu_reset_out : tb_overflow_flag);
        end
    endtask : wait_for
    // Reset, then release with an optional launch and subclock strobes
    task automatic restart(input logic go, input logic sub);
        sys_rst_in = 1'b1;
        tick(5);
        {sys_rst_in, wd_launch_in, subclk_tick_in} = {1'b0, go, sub};
        c0 = cycles;
        tick(1);
        wd_launch_in = 1'b0;
    endtask : restart
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        sys_rst_in = 1'b1;
        {tb_interval_sel_hi, tb_interval_sel_lo, tb_counter_clear_in, svc_en} = '0;
        {wd_clock_source_sel, wd_interval_sel_hi, wd_interval_sel_lo, wd_launch_in} = '0;
        {subclk_tick_in, ack_en, tb_irq_enable} = 3'b011;
        for (int s = 1; s >= 0; s--) begin
            {tb_interval_sel_hi, tb_interval_sel_lo} = 2'(s);
            restart(1'b0, 1'b0);
            wait_for(1'b0);
            check_bit("irq", 1'b1, tb_irq_out);
            c0 = cycles;
            tick(3);
            wait_for(1'b0);
            check_span("interval", 4096 << (2 * s), 4096 << (2 * s), cycles - c0);
        end
        {ack_en, tb_irq_enable} = 2'b00;
        tick(3);
        wait_for(1'b0);
        check_bit("masked irq", 1'b0, tb_irq_out);
        tb_irq_enable = 1'b1;
        tick(1);
        check_bit("enabled irq", 1'b1, tb_irq_out);
        ack_en = 1'b1;
        tick(3);
        check_bit("flag cleared", 1'b0, tb_overflow_flag);
        $display("test interval done");
        wd_clock_source_sel = 1'b1;
        restart(1'b1, 1'b0);
        check_bit("running", 1'b1, wd_running_out);
        wait_for(1'b1);
        check_span("tb dog", 14336, 18432, cycles - c0);
        tick(6);
        check_span("reset cycles", 4, 4, resets);
        $display("test tb dog done");
        // Clearing the time-base more often than its tap rises
        restart(1'b1, 1'b0);
        repeat (13) begin
            tick(1500);
            tb_counter_clear_in = 1'b1;
            tick(1);
            tb_counter_clear_in = 1'b0;
        end
        check_span("held off", 0, 0, resets);
        $display("test hold off done");
        wd_clock_source_sel = 1'b0;
        restart(1'b1, 1'b1);
        wait_for(1'b1);
        check_span("watch dog", 3584, 4608, cycles - c0);
        restart(1'b1, 1'b1);
        svc_en = 1'b1;
        tick(12000);
        check_span("serviced", 0, 0, resets);
        check_bit("still running", 1'b1, wd_running_out);
        $display("test watch dog done");
        end_sim();
    end
endmodule : testbench
